/* File: core/asp_pkg.sv */
// constants and helpers for the serial port with parity check
package asp_pkg;
  localparam int           CLK_HZ   = 125_000_000;
  localparam int           BAUD_BPS = 9600;
  localparam logic [15:0]  DIV_RST  = 16'(CLK_HZ / BAUD_BPS);
  localparam logic [7:0]   A_RESET  = 8'h00;
  localparam logic [7:0]   A_DATA   = 8'h04;
  localparam logic [7:0]   A_STAT   = 8'h08;
  localparam logic [7:0]   A_BAUD   = 8'h0C;
  localparam logic [7:0]   A_FMT    = 8'h10;
  localparam logic [7:0]   A_ERR    = 8'h14;
  localparam logic [7:0]   A_IE     = 8'h18;
  localparam logic [5:0]   FMT_RST  = 6'h03;
  localparam logic [7:0]   IE_RST   = 8'h00;
  localparam int           F_STOP   = 2;
  localparam int           F_PEN    = 3;
  localparam logic [1:0]   PS_ODD   = 2'h0;
  localparam logic [1:0]   PS_EVEN  = 2'h1;
  localparam logic [1:0]   PS_ONE   = 2'h2;
  localparam int           E_PAR    = 0;
  localparam int           E_FRM    = 1;
  localparam int           E_OVR    = 2;
  localparam int           E_BRK    = 3;
  localparam int           ST_IE    = 8;

  // keep only the configured number of data bits
  function automatic logic [7:0] asp_mask(input logic [7:0] d, input logic [5:0] f);
    asp_mask = d & (8'hFF >> (2'd3 - f[1:0]));
  endfunction

  // parity bit the frame must carry for this format
  function automatic logic asp_par(input logic [7:0] d, input logic [5:0] f);
    logic [7:0] m;
    m = asp_mask(d, f);
    unique case (f[5:4])
      PS_ODD:  asp_par = ~^m;
      PS_EVEN: asp_par = ^m;
      PS_ONE:  asp_par = 1'b1;
      default: asp_par = 1'b0;
    endcase
  endfunction

  // cycles of the closing stop time
  function automatic logic [16:0] asp_stop(input logic [15:0] dv, input logic [5:0] f);
    if (!f[F_STOP])
      asp_stop = {1'b0, dv};
    else if (f[1:0] == 2'h0)
      asp_stop = {1'b0, dv} + {2'h0, dv[15:1]};
    else
      asp_stop = {dv, 1'b0};
  endfunction
endpackage

/* File: core/asp_tx.sv */
// serial transmitter with one-character holding register
`timescale 1ns/10ps
`default_nettype none
module asp_tx
  import asp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clr,
  input  wire logic        load,
  input  wire logic [7:0]  load_data,
  input  wire logic [15:0] div,
  input  wire logic [5:0]  fmt,
  output logic             hold_full,
  output logic             idle,
  output logic             txd
);
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} asp_tx_st_t;
  asp_tx_st_t  st_reg, st_next;
  logic [16:0] cnt_reg, cnt_next;
  logic [2:0]  bit_reg, bit_next;
  logic [7:0]  shf_reg, shf_next, hold_reg, hold_next;
  logic        full_reg, full_next, txd_reg, txd_next, idle_reg, idle_next;
  logic        tick;
  logic [2:0]  last;

  assign tick      = (cnt_reg == 17'd1);
  assign last      = {1'b0, fmt[1:0]} + 3'd4;
  assign hold_full = full_reg;
  assign idle      = idle_reg;
  assign txd       = txd_reg;

  // frame sequencer; a queued character starts straight after the stop
  always_comb
  begin
    st_next = st_reg;
    cnt_next = (cnt_reg == 17'd0) ? cnt_reg : cnt_reg - 17'd1;
    bit_next = bit_reg;
    shf_next = shf_reg;
    hold_next = hold_reg;
    full_next = full_reg;
    txd_next = txd_reg;
    if (load && !full_reg)
    begin
      hold_next = load_data;
      full_next = 1'b1;
    end
    unique case (st_reg)
      T_IDLE:
        if (full_reg)
        begin
          st_next = T_START;
          shf_next = hold_reg;
          full_next = 1'b0;
          cnt_next = {1'b0, div};
          txd_next = 1'b0;
        end
      T_START:
        if (tick)
        begin
          st_next = T_DATA;
          bit_next = 3'd0;
          cnt_next = {1'b0, div};
          txd_next = shf_reg[0];
        end
      T_DATA:
        if (tick)
        begin
          cnt_next = {1'b0, div};
          if (bit_reg == last)
          begin
            if (fmt[F_PEN])
            begin
              st_next = T_PAR;
              txd_next = asp_par(shf_reg, fmt);
            end
            else
            begin
              st_next = T_STOP;
              cnt_next = asp_stop(div, fmt);
              txd_next = 1'b1;
            end
          end
          else
          begin
            bit_next = bit_reg + 3'd1;
            txd_next = shf_reg[bit_reg + 3'd1];
          end
        end
      T_PAR:
        if (tick)
        begin
          st_next = T_STOP;
          cnt_next = asp_stop(div, fmt);
          txd_next = 1'b1;
        end
      T_STOP:
        if (tick)
        begin
          if (full_reg)
          begin
            st_next = T_START;
            shf_next = hold_reg;
            full_next = 1'b0;
            cnt_next = {1'b0, div};
            txd_next = 1'b0;
          end
          else
            st_next = T_IDLE;
        end
    endcase
    if (clr)
    begin
      st_next = T_IDLE;
      full_next = 1'b0;
      txd_next = 1'b1;
      cnt_next = 17'd0;
    end
    // done only once the stop has left the line
    idle_next = (st_next == T_IDLE) && !full_next;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= T_IDLE;
      cnt_reg <= 17'd0;
      bit_reg <= 3'd0;
      shf_reg <= 8'h00;
      hold_reg <= 8'h00;
      full_reg <= 1'b0;
      txd_reg <= 1'b1;
      idle_reg <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      shf_reg <= shf_next;
      hold_reg <= hold_next;
      full_reg <= full_next;
      txd_reg <= txd_next;
      idle_reg <= idle_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_start_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg == T_START) |-> !txd_reg) else $error("start bit not low");
  a_stop_len: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg != T_STOP) ##1 (st_reg == T_STOP) |-> cnt_reg == asp_stop(div, fmt))
    else $error("stop time wrong");
  a_par_value: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg == T_PAR) |-> fmt[F_PEN] && txd_reg == asp_par(shf_reg, fmt))
    else $error("parity bit wrong");
  a_no_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_reg == T_STOP && tick && full_reg && !clr) |=> (st_reg == T_START && !txd_reg))
    else $error("gap between characters");
  a_idle_done: assert property (@(posedge hclk) disable iff (!hresetn)
    idle_reg |-> st_reg == T_IDLE && txd_reg) else $error("done while sending");
endmodule
`default_nettype wire

/* File: core/asp_top.sv */
// serial port top: AHB-Lite registers, receiver and transmitter
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module asp_top
  import asp_pkg::*;
#(
  parameter logic [15:0] DIV_INIT = DIV_RST
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rxd,
  output logic             txd,
  output logic             err_pending
);
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} asp_rx_st_t;

  // receiver state
  asp_rx_st_t  rst_reg, rst_next;
  logic [15:0] rcnt_reg, rcnt_next;
  logic [2:0]  rbit_reg, rbit_next;
  logic [7:0]  rshf_reg, rshf_next;
  logic        rpar_reg, rpar_next;
  logic        zero_reg, zero_next;
  logic        rprev_reg;
  logic        rtick;
  logic [2:0]  rlast;
  logic [15:0] half;
  logic        ev_done, ev_frm, ev_brk, ev_par;

  // register state
  logic [15:0] baud_reg, baud_next;
  logic [5:0]  fmt_reg, fmt_next;
  logic [7:0]  ie_reg, ie_next;
  logic [7:0]  rxb_reg, rxb_next;
  logic        rxf_reg, rxf_next;
  logic [3:0]  err_reg, err_next;
  logic        pend_reg, pend_next;
  logic [31:0] rd_reg, rd_next;
  logic        wp_reg, wp_next;
  logic [7:0]  wa_reg, wa_next;
  logic        clr_reg, clr_next;
  logic        acc, rd_acc, wr;
  logic        tx_load, tx_full, tx_idle, tx_line;
  logic [31:0] rval;

  assign hrdata      = rd_reg;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign txd         = tx_line;
  assign err_pending = pend_reg;

  //////////////////////////////////////////////////////////////////////////////
  // transmitter
  asp_tx u_tx (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clr       (clr_reg),
    .load      (tx_load),
    .load_data (wr ? hwdata[7:0] : 8'h00),
    .div       (baud_reg),
    .fmt       (fmt_reg),
    .hold_full (tx_full),
    .idle      (tx_idle),
    .txd       (tx_line)
  );

  //////////////////////////////////////////////////////////////////////////////
  // receiver: half a cell confirms the start, then one cell per bit
  assign rtick = (rcnt_reg == 16'd1);
  assign rlast = {1'b0, fmt_reg[1:0]} + 3'd4;
  assign half  = (baud_reg[15:1] == 15'd0) ? 16'd1 : {1'b0, baud_reg[15:1]};

  always_comb
  begin
    rst_next = rst_reg;
    rcnt_next = (rcnt_reg == 16'd0) ? rcnt_reg : rcnt_reg - 16'd1;
    rbit_next = rbit_reg;
    rshf_next = rshf_reg;
    rpar_next = rpar_reg;
    zero_next = zero_reg;
    ev_done = 1'b0;
    ev_frm = 1'b0;
    ev_brk = 1'b0;
    ev_par = 1'b0;
    unique case (rst_reg)
      R_IDLE:
        // edge only, so a held break does not restart frames
        if (rprev_reg && !rxd)
        begin
          rst_next = R_START;
          rcnt_next = half;
        end
      R_START:
        if (rtick)
        begin
          if (rxd)
          begin
            rst_next = R_IDLE;
            ev_frm = 1'b1;
          end
          else
          begin
            rst_next = R_DATA;
            rcnt_next = baud_reg;
            rbit_next = 3'd0;
            rshf_next = 8'h00;
            zero_next = 1'b1;
          end
        end
      R_DATA:
        if (rtick)
        begin
          rshf_next[rbit_reg] = rxd;
          zero_next = zero_reg & !rxd;
          rcnt_next = baud_reg;
          rbit_next = rbit_reg + 3'd1;
          if (rbit_reg == rlast)
            rst_next = fmt_reg[F_PEN] ? R_PAR : R_STOP;
        end
      R_PAR:
        if (rtick)
        begin
          rpar_next = rxd;
          zero_next = zero_reg & !rxd;
          rcnt_next = baud_reg;
          rst_next = R_STOP;
        end
      R_STOP:
        if (rtick)
        begin
          rst_next = R_IDLE;
          ev_done = 1'b1;
          ev_frm = !rxd;
          ev_brk = !rxd && zero_reg;
          // fixed one and zero senses are checked as well
          ev_par = fmt_reg[F_PEN] && (rpar_reg != asp_par(rshf_reg, fmt_reg));
        end
    endcase
    if (clr_reg)
    begin
      rst_next = R_IDLE;
      rcnt_next = 16'd0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rst_reg <= R_IDLE;
      rcnt_reg <= 16'd0;
      rbit_reg <= 3'd0;
      rshf_reg <= 8'h00;
      rpar_reg <= 1'b0;
      zero_reg <= 1'b0;
      rprev_reg <= 1'b1;
    end
    else
    begin
      rst_reg <= rst_next;
      rcnt_reg <= rcnt_next;
      rbit_reg <= rbit_next;
      rshf_reg <= rshf_next;
      rpar_reg <= rpar_next;
      zero_reg <= zero_next;
      rprev_reg <= rxd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, reads answered from the address phase
  assign acc     = hsel && htrans[1] && hready;
  assign rd_acc  = acc && !hwrite;
  assign wr      = wp_reg;
  assign tx_load = wr && (wa_reg == A_DATA);

  always_comb
  begin
    unique case (haddr[7:0])
      A_DATA:  rval = {24'h0000_00, rxb_reg};
      A_STAT:  rval = {16'h0000, ie_reg, err_reg, 1'b0, tx_idle, !tx_full, rxf_reg};
      A_BAUD:  rval = {16'h0000, baud_reg};
      A_FMT:   rval = {26'h000_0000, fmt_reg};
      A_ERR:   rval = {28'h000_0000, err_reg};
      A_IE:    rval = {24'h0000_00, ie_reg};
      default: rval = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    baud_next = baud_reg;
    fmt_next = fmt_reg;
    ie_next = ie_reg;
    rxb_next = rxb_reg;
    rxf_next = rxf_reg;
    err_next = err_reg;
    clr_next = 1'b0;
    wp_next = acc && hwrite;
    wa_next = acc ? haddr[7:0] : wa_reg;
    rd_next = rd_acc ? rval : rd_reg;
    // read side effects: data read frees the buffer, error read clears
    if (rd_acc && haddr[7:0] == A_DATA)
      rxf_next = 1'b0;
    if (rd_acc && haddr[7:0] == A_ERR)
      err_next = 4'h0;
    if (wr)
    begin
      unique case (wa_reg)
        A_RESET:
          if (hwdata != 32'h0000_0000)
          begin
            baud_next = DIV_INIT;
            ie_next = IE_RST;
            rxf_next = 1'b0;
            err_next = 4'h0;
            clr_next = 1'b1;
          end
        A_BAUD:  baud_next = hwdata[15:0];
        A_FMT:   fmt_next = hwdata[5:0];
        A_IE:    ie_next = hwdata[7:0];
        default: ;
      endcase
    end
    // a completed character wins over a same-cycle read or clear
    if (ev_done)
    begin
      rxb_next = asp_mask(rshf_reg, fmt_reg);
      // overrun only if the old character is still unread this cycle
      err_next[E_OVR] = err_next[E_OVR] | rxf_next;
      rxf_next = 1'b1;
    end
    err_next[E_PAR] = err_next[E_PAR] | ev_par;
    err_next[E_FRM] = err_next[E_FRM] | ev_frm | ev_brk;
    err_next[E_BRK] = err_next[E_BRK] | ev_brk;
    pend_next = |err_next;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      baud_reg <= DIV_INIT;
      fmt_reg <= FMT_RST;
      ie_reg <= IE_RST;
      rxb_reg <= 8'h00;
      rxf_reg <= 1'b0;
      err_reg <= 4'h0;
      pend_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
      wp_reg <= 1'b0;
      wa_reg <= 8'h00;
      clr_reg <= 1'b0;
    end
    else
    begin
      baud_reg <= baud_next;
      fmt_reg <= fmt_next;
      ie_reg <= ie_next;
      rxb_reg <= rxb_next;
      rxf_reg <= rxf_next;
      err_reg <= err_next;
      pend_reg <= pend_next;
      rd_reg <= rd_next;
      wp_reg <= wp_next;
      wa_reg <= wa_next;
      clr_reg <= clr_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  sequence s_held_char;
    ev_done && rxf_reg && !(rd_acc && haddr[7:0] == A_DATA);
  endsequence

  a_overrun_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    s_held_char |=> err_reg[E_OVR] && rxf_reg) else $error("overrun not flagged");
  a_parity_err: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev_done && !fmt_reg[F_PEN]) |-> !ev_par) else $error("parity checked while off");
  a_break_class: assert property (@(posedge hclk) disable iff (!hresetn)
    err_reg[E_BRK] |-> err_reg[E_FRM]) else $error("break without framing");
  a_err_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    ev_frm |=> err_reg[E_FRM] && pend_reg) else $error("error not pending");
  a_char_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    ev_done |=> rxf_reg && rxb_reg == $past(asp_mask(rshf_reg, fmt_reg)))
    else $error("character not stored");
  a_reset_fmt: assert property (@(posedge hclk) disable iff (!hresetn)
    clr_reg |-> baud_reg == DIV_INIT && fmt_reg == $past(fmt_reg))
    else $error("soft reset wrong");
endmodule
`default_nettype wire

/* File: test/asp_peer.sv */
// behavioural serial peripheral facing the port's txd and rxd pins
`timescale 1ns/10ps
`default_nettype none
module asp_peer
(
  input  wire logic hclk,
  input  wire logic txd,
  output logic      rxd
);
  int cyc;

  ////////////////////////////////////////////////////////////
  // free-running cycle count so frame starts can be compared
  initial cyc = 0;
  always @(posedge hclk)
    cyc <= cyc + 1;

  // the line idles at mark, so it is never left floating here
  initial rxd = 1'b1;

  ////////////////////////////////////////////////////////////
  // start cell, then nb cells lsb first, each dv cycles long
  task automatic send(input logic [11:0] v, input int nb, input int dv);
    int i;
    @(posedge hclk);
    rxd <= 1'b0;
    repeat (dv) @(posedge hclk);
    for (i = 0; i < nb; i++)
    begin
      rxd <= v[i];
      repeat (dv) @(posedge hclk);
    end
    rxd <= 1'b1;
  endtask

  // wait for a start cell, then sample every cell at its middle;
  // sampling on the falling clock edge keeps clear of txd updates
  task automatic grab(input int nb, input int dv, output logic [11:0] v, output int t0);
    int i;
    v = 12'h000;
    do @(negedge hclk); while (txd !== 1'b0);
    t0 = cyc;
    repeat (dv / 2) @(negedge hclk);
    v[0] = txd;
    for (i = 1; i <= nb; i++)
    begin
      repeat (dv) @(negedge hclk);
      v[i] = txd;
    end
  endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench: register bus, transmit framing, receive errors
`timescale 1ns/10ps
`default_nettype none
module testbench
  import asp_pkg::*;
;
  localparam int DV = 8;
  logic        hclk, hresetn, hsel, hwrite, rxd;
  logic        txd, err_pending, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          n_fail, cmp_count;

  ////////////////////////////////////////////////////////////
  // short bit time keeps every frame to a few dozen cycles
  asp_top #(.DIV_INIT(16'h0008)) asp_top_i
  (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hwdata      (hwdata),
    .hready      (hreadyout),
    .hrdata      (hrdata),
    .hreadyout   (hreadyout),
    .hresp       (hresp),
    .rxd         (rxd),
    .txd         (txd),
    .err_pending (err_pending)
  );

  asp_peer asp_peer_i (.hclk(hclk), .txd(txd), .rxd(rxd));

  initial hclk = 1'b0;
  always #4 hclk = ~hclk;

  ////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // a hang anywhere ends the run as a failure
  always @(posedge hclk)
  begin
    if (asp_peer_i.cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // single transfer; read data is taken at the edge that ends the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= 32'(a);
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0000_0000, r);
  endtask

  ////////////////////////////////////////////////////////////
  // expected frame pieces, worked out independently of the design
  function automatic logic [7:0] cut(input logic [7:0] d, input logic [5:0] f);
    return d & (8'hFF >> (3 - f[1:0]));
  endfunction

  function automatic logic pbit(input logic [7:0] m, input logic [5:0] f);
    case (f[5:4])
      2'h0: return ~^m;
      2'h1: return ^m;
      2'h2: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // cells of a frame from start up to the first stop cell, start at bit 0
  function automatic logic [11:0] frm(input logic [7:0] d, input logic [5:0] f,
                                      input logic pf, input logic stp);
    int n;
    n = 5 + f[1:0];
    frm = 12'(cut(d, f)) << 1;
    if (f[3])
    begin
      frm[n + 1] = pbit(cut(d, f), f) ^ pf;
      n++;
    end
    frm[n + 1] = stp;
  endfunction

  // start, data and parity cells; also the cell count after the start
  function automatic int fbits(input logic [5:0] f);
    return 6 + f[1:0] + f[3];
  endfunction

  function automatic int stopc(input int dv, input logic [5:0] f);
    if (!f[2])
      return dv;
    return (f[1:0] == 2'h0) ? dv + dv / 2 : 2 * dv;
  endfunction

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] r;
    rd(A_STAT, r);
    chk(r, 32'h0000_0006);
    rd(A_FMT, r);
    chk(r, 32'h0000_0003);
    rd(A_BAUD, r);
    chk(r, 32'(DV));
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, r);
    chk(r, 32'h0000_0000);
  endtask

  // two characters back to back per format, every length, sense and stop
  task automatic t_tx();
    logic [5:0]  fl [7] = '{6'h00, 6'h04, 6'h0C, 6'h1D, 6'h2A, 6'h3B, 6'h1B};
    logic [11:0] v1, v2;
    logic [31:0] r;
    int          t1, t2, dv, ln, i, k;
    for (i = 0; i < 7; i++)
    begin
      dv = 8 + 4 * (i % 2);
      ln = dv * fbits(fl[i]) + stopc(dv, fl[i]);
      wr(A_BAUD, 32'(dv));
      wr(A_FMT, 32'(fl[i]));
      fork
        begin
          asp_peer_i.grab(fbits(fl[i]), dv, v1, t1);
          asp_peer_i.grab(fbits(fl[i]), dv, v2, t2);
        end
        begin
          wr(A_DATA, 32'h0000_00A5);
          wr(A_DATA, 32'h0000_013C);
          rd(A_STAT, r);
          chk(r[2:1], 2'b00);
        end
      join
      chk(v1, frm(8'hA5, fl[i], 1'b0, 1'b1));
      chk(v2, frm(8'h3C, fl[i], 1'b0, 1'b1));
      chk(t2 - t1, ln);
      r = 32'h0000_0000;
      for (k = 0; k < 40 && r[2] !== 1'b1; k++)
        rd(A_STAT, r);
      chk(r, 32'h0000_0006);
      k = asp_peer_i.cyc - t2 - ln;
      chk(k >= 0 && k <= 10, 1'b1);
    end
  endtask

  // one received frame; e is the error set expected, data checked when clean
  task automatic rx1(input logic [5:0] f, input logic [7:0] d, input logic pf,
                     input logic [3:0] e);
    logic [31:0] r;
    wr(A_FMT, 32'(f));
    asp_peer_i.send(frm(d, f, pf, ~e[1]) >> 1, fbits(f), DV);
    chk(err_pending, 32'(e != 4'h0));
    rd(A_ERR, r);
    chk(r, 32'(e));
    chk(err_pending, 1'b0);
    rd(A_DATA, r);
    if (e == 4'h0)
      chk(r, 32'(cut(d, f)));
  endtask

  task automatic t_rx();
    logic [31:0] r;
    int          s;
    wr(A_BAUD, 32'(DV));
    for (s = 0; s < 4; s++)
    begin
      rx1(6'(11 + 16 * s), 8'h6B, 1'b0, 4'h0);
      rx1(6'(11 + 16 * s), 8'h6B, 1'b1, 4'h1);
    end
    rx1(6'h03, 8'hC5, 1'b1, 4'h0);
    rx1(6'h01, 8'hFF, 1'b0, 4'h0);
    rx1(6'h03, 8'h81, 1'b0, 4'h2);
    rx1(6'h03, 8'h00, 1'b0, 4'hA);
    asp_peer_i.send(12'h000, 0, 2);
    repeat (DV) @(posedge hclk);
    rd(A_ERR, r);
    chk(r, 32'h0000_0002);
  endtask

  // second character lands before the first is read
  task automatic t_overrun();
    logic [31:0] r;
    asp_peer_i.send(12'h111, 9, DV);
    rd(A_STAT, r);
    chk(r[0], 1'b1);
    asp_peer_i.send(12'h122, 9, DV);
    rd(A_ERR, r);
    chk(r, 32'h0000_0004);
    rd(A_DATA, r);
    chk(r, 32'h0000_0022);
    rd(A_STAT, r);
    chk(r[0], 1'b0);
  endtask

  task automatic t_soft();
    logic [31:0] r;
    wr(A_BAUD, 32'h0000_0014);
    wr(A_IE, 32'h0000_005A);
    wr(A_FMT, 32'h0000_001B);
    rd(A_STAT, r);
    chk(r, 32'h0000_5A06);
    wr(A_RESET, 32'h0000_0001);
    rd(A_BAUD, r);
    chk(r, 32'(DV));
    rd(A_FMT, r);
    chk(r, 32'h0000_001B);
    rd(A_STAT, r);
    chk(r, 32'h0000_0006);
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    n_fail = 0;
    cmp_count = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_overrun();
    t_soft();
    test_done();
  end
endmodule
`default_nettype wire
